// ==== verilog/dlt_pkg.sv ====
// Constants and types shared by the DDR read latency table block
package dlt_pkg;

   // ***************************************************
   // Read opcodes served by the table
   // ***************************************************
   localparam logic [7:0] OP_FAST_DDR_3B = 8'h0D;
   localparam logic [7:0] OP_FAST_DDR_4B = 8'h0E;
   localparam logic [7:0] OP_DUAL_DDR_3B = 8'hBD;
   localparam logic [7:0] OP_DUAL_DDR_4B = 8'hBE;
   localparam logic [7:0] OP_QUAD_DDR_3B = 8'hED;
   localparam logic [7:0] OP_QUAD_DDR_4B = 8'hEE;

   // ***************************************************
   // Query descriptor layout and fixed bytes
   // ***************************************************
   localparam logic [7:0] QRY_ID        = 8'h9A;
   localparam logic [7:0] QRY_LEN       = 8'h2A;
   localparam logic [7:0] QRY_ROWS      = 8'h05;
   localparam logic [7:0] QRY_ROW_LEN   = 8'h08;
   localparam logic [7:0] QRY_HDR_F     = 8'h46;
   localparam logic [7:0] QRY_HDR_C     = 8'h43;
   localparam logic [7:0] OFS_ID        = 8'h00;
   localparam logic [7:0] OFS_LEN       = 8'h01;
   localparam logic [7:0] OFS_ROWS      = 8'h02;
   localparam logic [7:0] OFS_ROW_LEN   = 8'h03;
   localparam logic [7:0] OFS_HDR       = 8'h04;
   localparam logic [7:0] OFS_ROW2      = 8'h0C;
   localparam logic [7:0] OFS_LAST      = 8'h2B;
   localparam logic [7:0] FREQ_50MHZ    = 8'h32;
   localparam logic [7:0] FREQ_66MHZ    = 8'h42;

   // ***************************************************
   // Latency codes and per-row cycle counts
   // ***************************************************
   localparam logic [1:0] LC_00 = 2'b00;
   localparam logic [1:0] LC_01 = 2'b01;
   localparam logic [1:0] LC_10 = 2'b10;
   localparam logic [1:0] LC_11 = 2'b11;
   localparam logic [7:0] MODE_NONE     = 8'h00;
   localparam logic [7:0] MODE_QUAD     = 8'h01;
   localparam logic [7:0] LAT11_FAST    = 8'h04;
   localparam logic [7:0] LAT11_DUAL    = 8'h04;
   localparam logic [7:0] LAT11_QUAD    = 8'h03;
   localparam logic [7:0] LAT00_FAST    = 8'h05;
   localparam logic [7:0] LAT00_DQ      = 8'h06;
   localparam logic [7:0] LAT01_FAST    = 8'h06;
   localparam logic [7:0] LAT01_DQ      = 8'h07;
   localparam logic [7:0] LAT10_FAST    = 8'h07;
   localparam logic [7:0] LAT10_DQ      = 8'h08;

   // ***************************************************
   // Read command kinds, ordered as the table columns
   // ***************************************************
   typedef enum logic [1:0] {
      DLT_FAST,
      DLT_DUAL,
      DLT_QUAD
   } dlt_kind_type;

endpackage

// ==== verilog/dlt_opcode_dec.sv ====
// Opcode decoder for the DDR read commands
`timescale 1ns/100ps
module dlt_opcode_dec
   import dlt_pkg::*;
(
   // Opcode in
   input  wire logic [7:0]   opcode_i,
   // Decode out
   output logic              hit_o,
   output dlt_kind_type      kind_o,
   output logic              four_byte_o
);

   // Pure table lookup; unknown opcodes leave the table untouched
   always_comb begin
      hit_o       = 1'b1;
      kind_o      = DLT_FAST;
      four_byte_o = 1'b0;
      unique case (opcode_i)
         OP_FAST_DDR_3B: kind_o = DLT_FAST;
         OP_FAST_DDR_4B: begin
            kind_o      = DLT_FAST;
            four_byte_o = 1'b1;
         end
         OP_DUAL_DDR_3B: kind_o = DLT_DUAL;
         OP_DUAL_DDR_4B: begin
            kind_o      = DLT_DUAL;
            four_byte_o = 1'b1;
         end
         OP_QUAD_DDR_3B: kind_o = DLT_QUAD;
         OP_QUAD_DDR_4B: begin
            kind_o      = DLT_QUAD;
            four_byte_o = 1'b1;
         end
         default: hit_o = 1'b0;
      endcase
   end

endmodule

// ==== verilog/dlt_query_rom.sv ====
// Query descriptor bytes and the latency lookup taken from them
`timescale 1ns/100ps
module dlt_query_rom
   import dlt_pkg::*;
(
   // Query byte port
   input  wire logic [7:0]   qry_addr_i,
   output logic [7:0]        qry_byte_o,
   // Latency lookup port
   input  wire logic [1:0]   lat_code_i,
   input  dlt_kind_type      kind_i,
   output logic [7:0]        mode_cnt_o,
   output logic [7:0]        lat_cnt_o
);

   // One descriptor image serves both the host query and the sequencer
   function automatic logic [7:0] rom_byte(input logic [7:0] a);
      unique case (a)
         OFS_ID:      rom_byte = QRY_ID;
         OFS_LEN:     rom_byte = QRY_LEN;
         OFS_ROWS:    rom_byte = QRY_ROWS;
         OFS_ROW_LEN: rom_byte = QRY_ROW_LEN;
         8'h04: rom_byte = QRY_HDR_F;
         8'h05: rom_byte = QRY_HDR_C;
         8'h06: rom_byte = OP_FAST_DDR_3B;
         8'h07: rom_byte = OP_FAST_DDR_4B;
         8'h08: rom_byte = OP_DUAL_DDR_3B;
         8'h09: rom_byte = OP_DUAL_DDR_4B;
         8'h0A: rom_byte = OP_QUAD_DDR_3B;
         8'h0B: rom_byte = OP_QUAD_DDR_4B;
         8'h0C: rom_byte = FREQ_50MHZ;
         8'h0D: rom_byte = {6'h00, LC_11};
         8'h0F: rom_byte = LAT11_FAST;
         8'h11: rom_byte = LAT11_DUAL;
         8'h12: rom_byte = MODE_QUAD;
         8'h13: rom_byte = LAT11_QUAD;
         8'h14: rom_byte = FREQ_66MHZ;
         8'h15: rom_byte = {6'h00, LC_00};
         8'h17: rom_byte = LAT00_FAST;
         8'h19: rom_byte = LAT00_DQ;
         8'h1A: rom_byte = MODE_QUAD;
         8'h1B: rom_byte = LAT00_DQ;
         8'h1C: rom_byte = FREQ_66MHZ;
         8'h1D: rom_byte = {6'h00, LC_01};
         8'h1F: rom_byte = LAT01_FAST;
         8'h21: rom_byte = LAT01_DQ;
         8'h22: rom_byte = MODE_QUAD;
         8'h23: rom_byte = LAT01_DQ;
         8'h24: rom_byte = FREQ_66MHZ;
         8'h25: rom_byte = {6'h00, LC_10};
         8'h27: rom_byte = LAT10_FAST;
         8'h29: rom_byte = LAT10_DQ;
         8'h2A: rom_byte = MODE_QUAD;
         8'h2B: rom_byte = LAT10_DQ;
         default: rom_byte = MODE_NONE;   // Mode bytes of fast/dual, and past end
      endcase
   endfunction

   // Row base for a latency code, in descriptor row order
   function automatic logic [7:0] row_base(input logic [1:0] code);
      unique case (code)
         LC_11: row_base = OFS_ROW2;
         LC_00: row_base = OFS_ROW2 + QRY_ROW_LEN;
         LC_01: row_base = OFS_ROW2 + 8'(2 * QRY_ROW_LEN);
         LC_10: row_base = OFS_ROW2 + 8'(3 * QRY_ROW_LEN);
      endcase
   endfunction

   logic [7:0] pair_ofs;

   // Mode byte sits two past the row start, one column pair per kind
   always_comb begin
      pair_ofs   = row_base(lat_code_i) + 8'h02 + {5'h00, kind_i, 1'b0};
      qry_byte_o = rom_byte(qry_addr_i);
      mode_cnt_o = rom_byte(pair_ofs);
      lat_cnt_o  = rom_byte(pair_ofs + 8'h01);
   end

endmodule

// ==== verilog/dlt_latency_seq.sv ====
// DDR read latency sequencer and query descriptor reader
`timescale 1ns/100ps
// ***************************************************
// ***************************************************
module dlt_latency_seq
   import dlt_pkg::*;
#(
   parameter int CNT_W = 4
)
(
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   // Serial front end
   input  wire logic         cs_active_i,
   input  wire logic         sck_edge_i,
   input  wire logic         cmd_valid_i,
   input  wire logic [7:0]   cmd_opcode_i,
   input  wire logic         addr_done_i,
   input  wire logic [1:0]   lat_code_i,
   // Phase outputs
   output logic              ddr_read_o,
   output logic [1:0]        io_kind_o,
   output logic              addr_four_byte_o,
   output logic              mode_phase_o,
   output logic              dummy_phase_o,
   output logic              data_phase_o,
   output logic              data_start_o,
   // Query port
   input  wire logic         qry_rd_i,
   input  wire logic [7:0]   qry_addr_i,
   output logic              qry_valid_o,
   output logic              qry_in_range_o,
   output logic [7:0]        qry_data_o
);

   // Counts reach 8, so fewer bits cannot hold the longest latency
   if (CNT_W < 4) begin : g_cnt_check
      $error("CNT_W must be at least 4");
   end

   // ***************************************************
   // State
   // ***************************************************
   typedef enum logic [2:0] {
      DLT_IDLE,
      DLT_ADDR,
      DLT_MODE,
      DLT_LAT,
      DLT_DATA
   } dlt_state_type;

   typedef struct packed {
      dlt_state_type       st;
      dlt_kind_type        kind;
      logic                four;
      logic [1:0]          code;
      logic [CNT_W-1:0]    mode;
      logic [CNT_W-1:0]    lat;
      logic [CNT_W-1:0]    cnt;
      logic                start;
      logic                qv;
      logic                qin;
      logic [7:0]          qdata;
   } dlt_regs_type;

   dlt_regs_type r_q;
   dlt_regs_type r_d;

   logic             dec_hit;
   dlt_kind_type     dec_kind;
   logic             dec_four;
   logic [7:0]       qry_byte;
   logic [7:0]       mode_cnt;
   logic [7:0]       lat_cnt;

   // ***************************************************
   // Decode and table lookup
   // ***************************************************
   dlt_opcode_dec u_dec (
      .opcode_i    (cmd_opcode_i),
      .hit_o       (dec_hit),
      .kind_o      (dec_kind),
      .four_byte_o (dec_four)
   );

   // Lookup uses the live code; it is frozen when the command is taken
   dlt_query_rom u_rom (
      .qry_addr_i  (qry_addr_i),
      .qry_byte_o  (qry_byte),
      .lat_code_i  (lat_code_i),
      .kind_i      (dec_kind),
      .mode_cnt_o  (mode_cnt),
      .lat_cnt_o   (lat_cnt)
   );

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      r_d       = r_q;
      r_d.start = 1'b0;
      r_d.qv    = qry_rd_i;
      // Query reads answer one cycle later from the descriptor image
      if (qry_rd_i) begin
         r_d.qin   = (qry_addr_i <= OFS_LAST);
         r_d.qdata = qry_byte;
      end
      unique case (r_q.st)
         DLT_IDLE: begin
            if (cmd_valid_i && cs_active_i && dec_hit) begin
               r_d.st   = DLT_ADDR;
               r_d.kind = dec_kind;
               r_d.four = dec_four;
               r_d.code = lat_code_i;
               r_d.mode = CNT_W'(mode_cnt);
               r_d.lat  = CNT_W'(lat_cnt);
            end
         end
         DLT_ADDR: begin
            // Skip empty phases so data never waits an extra cycle
            if (addr_done_i) begin
               if (r_q.mode != '0) begin
                  r_d.st  = DLT_MODE;
                  r_d.cnt = r_q.mode;
               end else if (r_q.lat != '0) begin
                  r_d.st  = DLT_LAT;
                  r_d.cnt = r_q.lat;
               end else begin
                  r_d.st    = DLT_DATA;
                  r_d.start = 1'b1;
               end
            end
         end
         DLT_MODE: begin
            if (sck_edge_i) begin
               r_d.cnt = r_q.cnt - CNT_W'(1);
               if (r_q.cnt == CNT_W'(1)) begin
                  if (r_q.lat != '0) begin
                     r_d.st  = DLT_LAT;
                     r_d.cnt = r_q.lat;
                  end else begin
                     r_d.st    = DLT_DATA;
                     r_d.start = 1'b1;
                  end
               end
            end
         end
         DLT_LAT: begin
            if (sck_edge_i) begin
               r_d.cnt = r_q.cnt - CNT_W'(1);
               if (r_q.cnt == CNT_W'(1)) begin
                  r_d.st    = DLT_DATA;
                  r_d.start = 1'b1;
               end
            end
         end
         DLT_DATA: ;
      endcase
      // Chip select release ends any command, wherever it stands
      if (!cs_active_i) begin
         r_d.st    = DLT_IDLE;
         r_d.start = 1'b0;
         r_d.cnt   = '0;
      end
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         r_q.st    <= DLT_IDLE;
         r_q.kind  <= DLT_FAST;
         r_q.four  <= 1'b0;
         r_q.code  <= LC_00;
         r_q.mode  <= '0;
         r_q.lat   <= '0;
         r_q.cnt   <= '0;
         r_q.start <= 1'b0;
         r_q.qv    <= 1'b0;
         r_q.qin   <= 1'b0;
         r_q.qdata <= 8'h00;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state register
   assign ddr_read_o       = (r_q.st != DLT_IDLE);
   assign io_kind_o        = r_q.kind;
   assign addr_four_byte_o = r_q.four;
   assign mode_phase_o     = (r_q.st == DLT_MODE);
   assign dummy_phase_o    = (r_q.st == DLT_LAT);
   assign data_phase_o     = (r_q.st == DLT_DATA);
   assign data_start_o     = r_q.start;
   assign qry_valid_o      = r_q.qv;
   assign qry_in_range_o   = r_q.qin;
   assign qry_data_o       = r_q.qdata;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   wire take = cmd_valid_i && cs_active_i && (r_q.st == DLT_IDLE);

   a_fast_opcode_taken: assert property (
      take && (cmd_opcode_i == 8'h0D || cmd_opcode_i == 8'h0E) |=>
         r_q.st == DLT_ADDR && r_q.kind == DLT_FAST
         && r_q.four == ($past(cmd_opcode_i) == 8'h0E))
      else $error("Fast DDR opcode not taken");

   a_dual_opcode_taken: assert property (
      take && (cmd_opcode_i == 8'hBD || cmd_opcode_i == 8'hBE) |=>
         r_q.st == DLT_ADDR && r_q.kind == DLT_DUAL)
      else $error("Dual DDR opcode not taken");

   a_quad_opcode_taken: assert property (
      take && (cmd_opcode_i == 8'hED || cmd_opcode_i == 8'hEE) |=>
         r_q.st == DLT_ADDR && r_q.kind == DLT_QUAD)
      else $error("Quad DDR opcode not taken");

   a_code11_latency: assert property (
      r_q.st == DLT_ADDR && r_q.code == 2'b11 |->
         r_q.lat == ((r_q.kind == DLT_QUAD) ? 4'd3 : 4'd4))
      else $error("Latency wrong for code 11b");

   a_code00_latency: assert property (
      r_q.st == DLT_ADDR && r_q.code == 2'b00 |->
         r_q.lat == ((r_q.kind == DLT_FAST) ? 4'd5 : 4'd6))
      else $error("Latency wrong for code 00b");

   a_code01_latency: assert property (
      r_q.st == DLT_ADDR && r_q.code == 2'b01 |->
         r_q.lat == ((r_q.kind == DLT_FAST) ? 4'd6 : 4'd7))
      else $error("Latency wrong for code 01b");

   a_code10_latency: assert property (
      r_q.st == DLT_ADDR && r_q.code == 2'b10 |->
         r_q.lat == ((r_q.kind == DLT_FAST) ? 4'd7 : 4'd8))
      else $error("Latency wrong for code 10b");

   a_quad_mode_cycle: assert property (
      r_q.st == DLT_ADDR && addr_done_i && cs_active_i |=>
         (r_q.kind == DLT_QUAD) == mode_phase_o)
      else $error("Mode phase does not match command kind");

   // One serial clock ends the mode phase; every row has latency after it
   a_mode_one_edge: assert property (
      mode_phase_o && sck_edge_i && cs_active_i |=> !mode_phase_o && dummy_phase_o)
      else $error("Mode phase not exactly one serial clock");

   a_lat_to_data: assert property (
      dummy_phase_o && sck_edge_i && cs_active_i && r_q.cnt == CNT_W'(1)
         |=> data_start_o && data_phase_o)
      else $error("Data did not follow the last latency cycle");

   // A second opcode mid-read must not disturb the running command
   a_busy_cmd_ignored: assert property (
      cmd_valid_i && ddr_read_o && cs_active_i |=>
         $stable(io_kind_o) && $stable(addr_four_byte_o))
      else $error("Command taken while busy");

   a_start_one_pulse: assert property (
      data_start_o |=> !data_start_o)
      else $error("Data start longer than one cycle");

   a_query_id_byte: assert property (
      qry_rd_i && qry_addr_i == 8'h00 |=> qry_valid_o && qry_data_o == 8'h9A)
      else $error("Query id byte wrong");

   a_query_length: assert property (
      qry_rd_i && qry_addr_i == 8'h01 |=> qry_data_o == 8'h2A)
      else $error("Query length byte wrong");

   a_query_header: assert property (
      qry_rd_i && qry_addr_i == 8'h04 |=> qry_data_o == 8'h46)
      else $error("Query header byte wrong");

   a_query_row_freq: assert property (
      qry_rd_i && qry_addr_i == 8'h0C |=> qry_data_o == 8'h32)
      else $error("Query row frequency wrong");

   c_quad_read_data: cover property (
      $rose(mode_phase_o) ##[1:40] data_start_o);
   c_fast_read_data: cover property (
      r_q.st == DLT_ADDR && r_q.kind == DLT_FAST ##[1:40] data_start_o);
   c_abort_in_latency: cover property (
      dummy_phase_o ##1 !cs_active_i);
   c_query_last_byte: cover property (
      qry_rd_i && qry_addr_i == 8'h2B);

endmodule

// ==== tb/dlt_host_model.sv ====
// Host controller model that issues DDR reads and counts mode and latency clocks
`timescale 1ns/100ps
module dlt_host_model (
   // Clock
   input  wire logic         mclk_i,
   // Toward the block
   output logic              cs_active_o,
   output logic              sck_edge_o,
   output logic              cmd_valid_o,
   output logic [7:0]        cmd_opcode_o,
   output logic              addr_done_o,
   output logic [1:0]        lat_code_o,
   // From the block
   input  wire logic         mode_phase_i,
   input  wire logic         dummy_phase_i,
   input  wire logic         data_phase_i,
   input  wire logic         data_start_i
);
   // Idle levels, deselected from time zero
   initial begin
      cs_active_o = 1'b0;
      sck_edge_o = 1'b0;
      cmd_valid_o = 1'b0;
      cmd_opcode_o = 8'h00;
      addr_done_o = 1'b0;
      lat_code_o = 2'b00;
   end

   // One opcode; released lines show the inverse so stale values never match
   task automatic send_cmd(input logic [7:0] op, input logic [1:0] code);
      cs_active_o = 1'b1;
      lat_code_o = code;
      cmd_valid_o = 1'b1;
      cmd_opcode_o = op;
      @(posedge mclk_i) #1;
      cmd_valid_o = 1'b0;
      cmd_opcode_o = ~op;
   endtask

   // Whole read; gap stretches the serial clock like a slow host
   task automatic run_read(input logic [7:0] op, input logic [1:0] code, input int gap,
                           output int mode_n, output int lat_n, output logic start_seen);
      mode_n = 0;
      lat_n = 0;
      start_seen = 1'b0;
      send_cmd(op, code);
      addr_done_o = 1'b1;
      @(posedge mclk_i) #1;
      addr_done_o = 1'b0;
      // Clock until data shows, bounded so a stuck phase cannot hang us
      for (int i = 0; i < 20; i++) begin
         if (data_phase_i === 1'b1) begin
            start_seen = data_start_i;
            break;
         end
         if (mode_phase_i === 1'b1)
            mode_n++;
         else if (dummy_phase_i === 1'b1)
            lat_n++;
         // Drop the pulse only when a gap follows, so it never toggles twice at once
         if (gap > 0) begin
            sck_edge_o = 1'b0;
            repeat (gap) @(posedge mclk_i) #1;
         end
         sck_edge_o = 1'b1;
         @(posedge mclk_i) #1;
      end
      sck_edge_o = 1'b0;
   endtask

   // Address end and a few serial clocks, leaving the read mid-way
   task automatic advance(input int n);
      addr_done_o = 1'b1;
      @(posedge mclk_i) #1;
      addr_done_o = 1'b0;
      repeat (n) begin
         sck_edge_o = 1'b1;
         @(posedge mclk_i) #1;
      end
      sck_edge_o = 1'b0;
   endtask

   // Deselect ends any transfer
   task automatic release_cs();
      cs_active_o = 1'b0;
      @(posedge mclk_i) #1;
   endtask
endmodule

// ==== tb/ddr_read_latency_table_tb.sv ====
// Self-checking bench for the DDR read latency sequencer
`timescale 1ns/100ps
module ddr_read_latency_table_tb;
   import dlt_pkg::*;
   logic       mclk_i, srst_i, cs_act, sck_edge, cmd_valid, addr_done, qry_rd;
   logic [7:0] cmd_op, qry_addr, qry_data;
   logic [1:0] lat_code, io_kind;
   logic       ddr_read, four_b, mode_ph, dummy_ph, data_ph, data_start, qry_valid, qry_in;
   int         err_total, comparisons;
   logic [7:0] ops [0:5] = '{8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
   logic [7:0] hdr [0:11] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
                              8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};

   // ***************************************************
   // Clock, host model and block
   // ***************************************************
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   dlt_host_model host (.mclk_i(mclk_i), .cs_active_o(cs_act), .sck_edge_o(sck_edge),
      .cmd_valid_o(cmd_valid), .cmd_opcode_o(cmd_op), .addr_done_o(addr_done),
      .lat_code_o(lat_code), .mode_phase_i(mode_ph), .dummy_phase_i(dummy_ph),
      .data_phase_i(data_ph), .data_start_i(data_start));

   dlt_latency_seq #(.CNT_W(4)) DUT (.mclk_i(mclk_i), .srst_i(srst_i),
      .cs_active_i(cs_act), .sck_edge_i(sck_edge), .cmd_valid_i(cmd_valid),
      .cmd_opcode_i(cmd_op), .addr_done_i(addr_done), .lat_code_i(lat_code),
      .ddr_read_o(ddr_read), .io_kind_o(io_kind), .addr_four_byte_o(four_b),
      .mode_phase_o(mode_ph), .dummy_phase_o(dummy_ph), .data_phase_o(data_ph),
      .data_start_o(data_start), .qry_rd_i(qry_rd), .qry_addr_i(qry_addr),
      .qry_valid_o(qry_valid), .qry_in_range_o(qry_in), .qry_data_o(qry_data));

   // ***************************************************
   // Expectations and comparison
   // ***************************************************
   // Latency per code, kind 0 fast, 1 dual, 2 quad
   function automatic logic [7:0] exp_lat(input logic [1:0] code, input int kind);
      case (code)
         2'b11: return (kind == 2) ? 8'h03 : 8'h04;
         2'b00: return (kind == 0) ? 8'h05 : 8'h06;
         2'b01: return (kind == 0) ? 8'h06 : 8'h07;
         default: return (kind == 0) ? 8'h07 : 8'h08;
      endcase
   endfunction

   // Descriptor byte; rows hold limit, code, then mode and latency per kind
   function automatic logic [7:0] exp_byte(input int a);
      int         r;
      int         c;
      logic [1:0] code;
      if (a < 12)
         return hdr[a];
      if (a > 43)
         return 8'h00;
      r = (a - 12) / 8;
      c = (a - 12) % 8;
      code = (r == 0) ? 2'b11 : 2'(r - 1);
      if (c == 0)
         return (r == 0) ? 8'h32 : 8'h42;
      if (c == 1)
         return {6'h00, code};
      if (c % 2 == 0)
         return (c == 6) ? 8'h01 : 8'h00;
      return exp_lat(code, (c - 3) / 2);
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   // Every opcode under every code, host speed varied
   task automatic test_reads();
      int   m;
      int   l;
      logic s;
      for (int code = 0; code < 4; code++) begin
         for (int i = 0; i < 6; i++) begin
            host.run_read(ops[i], 2'(code), (i + code) % 3, m, l, s);
            check("ddr_read", {7'h00, ddr_read}, 8'h01);
            check("io_kind", {6'h00, io_kind}, 8'(i / 2));
            check("four_byte", {7'h00, four_b}, 8'(i % 2));
            check("mode_cycles", 8'(m), (i / 2 == 2) ? 8'h01 : 8'h00);
            check("lat_cycles", 8'(l), exp_lat(2'(code), i / 2));
            check("data_start", {7'h00, s}, 8'h01);
            host.release_cs();
            check("ddr_read_end", {7'h00, ddr_read}, 8'h00);
         end
      end
   endtask

   // Unknown opcode and a command while busy are both ignored
   task automatic test_refused();
      host.send_cmd(8'h0B, 2'b00);
      check("foreign_op", {7'h00, ddr_read}, 8'h00);
      host.release_cs();
      host.send_cmd(8'hED, 2'b01);
      // Let an edge pass so the strobe is not raised as it falls
      @(posedge mclk_i) #1;
      host.send_cmd(8'h0E, 2'b11);
      check("busy_kind", {6'h00, io_kind}, 8'h02);
      check("busy_four", {7'h00, four_b}, 8'h00);
      // Mode cycle and one latency cycle, then deselect mid-latency
      host.advance(2);
      check("abort_lat", {7'h00, dummy_ph}, 8'h01);
      host.release_cs();
      check("abort", {6'h00, ddr_read, data_ph}, 8'h00);
   endtask

   // Back-to-back descriptor reads, past its end, down to the identifier
   task automatic test_query();
      qry_rd = 1'b1;
      for (int a = 45; a >= 0; a--) begin
         qry_addr = 8'(a);
         @(posedge mclk_i) #1;
         check("qry_valid", {7'h00, qry_valid}, 8'h01);
         check("qry_data", qry_data, exp_byte(a));
         check("qry_in_range", {7'h00, qry_in}, (a <= 43) ? 8'h01 : 8'h00);
      end
      qry_rd = 1'b0;
      qry_addr = 8'h55;
      @(posedge mclk_i) #1;
      check("qry_idle", {7'h00, qry_valid}, 8'h00);
      check("qry_held", qry_data, 8'h9A);
   endtask

   // ***************************************************
   // Run control
   // ***************************************************
   task automatic finish_test();
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run is a few hundred cycles; this leaves ample margin
   initial begin
      #200000;
      err_total++;
      finish_test();
   end

   initial begin
      err_total = 0;
      comparisons = 0;
      srst_i = 1'b1;
      qry_rd = 1'b0;
      qry_addr = 8'h00;
      repeat (10) @(posedge mclk_i);
      #1;
      srst_i = 1'b0;
      check("rst_read", {7'h00, ddr_read}, 8'h00);
      check("rst_qry", qry_data, 8'h00);
      test_reads();
      test_refused();
      test_query();
      finish_test();
   end
endmodule
